//--- iprs_pkg.sv
// iprs_pkg: register map, field layout and timing constants
package iprs_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIME_BASE = 8'hC3;
    localparam logic [7:0] IDX_PWR_CTRL = 8'hE1;
    localparam logic [7:0] IDX_RDIS_0 = 8'hE2;
    localparam logic [7:0] IDX_RDIS_1 = 8'hE3;
    localparam logic [7:0] IDX_RDIS_2 = 8'hE4;
    localparam logic [7:0] IDX_RDIS_3 = 8'hE5;
    localparam logic [7:0] IDX_RDIS_4 = 8'hE6;
    localparam logic [7:0] IDX_RDIS_5 = 8'hE7;
    localparam logic [7:0] IDX_RUN_CTRL = 8'hF0;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hF1;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hF2;
    localparam logic [7:0] IDX_ACTIVE = 8'hF3;
    // reset values
    localparam logic [15:0] RST_SETTING = 16'h0000;
    // time base field and codes
    localparam int TB_W = 4;
    localparam logic [3:0] TB_10MS = 4'h0;
    localparam logic [3:0] TB_1MS = 4'h1;
    localparam logic [3:0] TB_100US = 4'h2;
    localparam logic [6:0] SUB_PER_10MS = 7'h64;
    localparam logic [6:0] SUB_PER_1MS = 7'h0A;
    localparam logic [6:0] SUB_PER_100US = 7'h01;
    // power-off word layout
    localparam int PWR_DLY_W = 8;
    localparam int PWR_EN_BIT = 15;
    localparam logic [7:0] PWR_DLY_MAX = 8'h0A;
    // run control bits
    localparam int RUN_BIT = 0;
    localparam int HALT_CLR_BIT = 1;
    // interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_CONFIRM = 0;
    localparam int IRQ_HOST_FAULT = 1;
    localparam int IRQ_SKIP = 2;
    // refresh units
    localparam int UNITS = 96;
    localparam logic [6:0] UNIT_LIMIT = 7'h60;
    localparam logic [3:0] WORDS_PER_UNIT = 4'hA;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int SUB_TICK_NS = 100000;
    localparam int SUB_TICK_CYC = SUB_TICK_NS * CLK_MHZ / 1000;
    localparam logic [3:0] SUB_PER_MS = 4'hA;
endpackage : iprs_pkg

//--- iprs_pwr_delay.sv
// iprs_pwr_delay: counts millisecond ticks from supply-drop detection
`timescale 1ns/100ps
`default_nettype none
module iprs_pwr_delay (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic detect_i,
    input wire logic ms_tick_i,
    input wire logic [7:0] delay_i,
    output logic confirm_o
);
    logic [7:0] cnt_reg;
    logic [7:0] dly_eff;

    // settings above the top code are clipped so the wait stays bounded
    assign dly_eff = (delay_i > iprs_pkg::PWR_DLY_MAX) ?
                     iprs_pkg::PWR_DLY_MAX : delay_i;

    // counter cleared while no drop is seen, stops once confirmed
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 8'h00;
        end else if (!detect_i) begin
            cnt_reg <= 8'h00;
        end else if (ms_tick_i && (cnt_reg < dly_eff)) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // confirmation holds until the drop goes away
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            confirm_o <= 1'b0;
        end else begin
            confirm_o <= detect_i && (cnt_reg == dly_eff);
        end
    end

    a_confirm_count: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) $rose(confirm_o) |-> $past(cnt_reg) == dly_eff)
        else $error("confirmation before programmed count");
endmodule : iprs_pwr_delay
`default_nettype wire

//--- iprs_top.sv
// iprs_top: interrupt, power-off and refresh setup register bank
// Function
// - Time-base code: 0 is 10 ms, 1 is 1 ms, 2 is 0.1 ms; default 0.
// - The time base is taken only at run start, never while running.
// - Drop confirmation waits 0 to 10 ms in 1 ms steps; default none.
// - With the power-off task enabled, a confirmed drop launches it.
// - With the task disabled, a confirmed drop resets the CPU and halts.
// - Bit 15 of the power-off word enables the task; default off.
// - Delay and enable are taken at startup or run start only.
// - One disable bit per module; a set bit skips its 10-word exchange.
// - An explicit refresh instruction serves a disabled module too.
`timescale 1ns/100ps
`default_nettype none
module iprs_top #(
    parameter int TICK_CYCLES = iprs_pkg::SUB_TICK_CYC
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // avalon-mm slave
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // supply supervision
    input wire logic pwr_drop_i,
    output logic pwr_task_o,
    output logic cpu_reset_o,
    // operation state
    output logic run_o,
    output logic sched_tick_o,
    output logic [3:0] time_base_o,
    // refresh requests from the scan sequencer
    input wire logic refresh_req_i,
    input wire logic [6:0] refresh_unit_i,
    input wire logic io_refresh_instruction_i,
    output logic refresh_go_o,
    output logic refresh_skip_o,
    output logic [9:0] refresh_base_o,
    // module supervision
    input wire logic host_fault_indicator_i,
    output logic irq_o
);
    logic [15:0] tb_reg;
    logic [15:0] pwr_reg;
    logic [95:0] rdis_reg;
    logic [3:0] tb_act_reg;
    logic [7:0] dly_act_reg;
    logic en_act_reg;
    logic [95:0] rdis_act_reg;
    logic startup_reg;
    logic halt_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_stat_next;
    logic [2:0] irq_mask_reg;
    logic [15:0] sub_cnt_reg;
    logic sub_tick_reg;
    logic [3:0] ms_cnt_reg;
    logic ms_tick;
    logic [6:0] sched_cnt_reg;
    logic [6:0] sched_len;
    logic confirm;
    logic confirm_d_reg;
    logic confirm_rise;
    logic [7:0] idx;
    logic bus_req;
    logic wr_acc;
    logic run_start;
    logic capture;
    logic req_ok;
    logic go;
    logic [31:0] rd_mux;

    // decode of one 16-bit slice of the disable bank
    function automatic logic [15:0] rdis_word(input logic [95:0] bank,
                                              input logic [2:0] sel);
        rdis_word = bank[sel * 16 +: 16];
    endfunction : rdis_word

    // base of a module's allocated words in the refresh area
    function automatic logic [9:0] unit_base(input logic [6:0] unit);
        unit_base = 10'(unit) * 10'(iprs_pkg::WORDS_PER_UNIT);
    endfunction : unit_base

    assign idx = avs_address_i[9:2];
    assign bus_req = avs_read_i || avs_write_i;
    // a write lands at the edge where waitrequest is seen low
    assign wr_acc = avs_write_i && !avs_waitrequest_o;
    assign run_start = wr_acc && (idx == iprs_pkg::IDX_RUN_CTRL) &&
                       avs_writedata_i[iprs_pkg::RUN_BIT] &&
                       !run_o && !halt_reg;
    assign capture = startup_reg || run_start;

    // one wait state: waitrequest drops for one cycle after a request
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
        end
    end

    // read mux; unmapped indices read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            iprs_pkg::IDX_TIME_BASE: rd_mux[15:0] = tb_reg;
            iprs_pkg::IDX_PWR_CTRL: rd_mux[15:0] = pwr_reg;
            iprs_pkg::IDX_RDIS_0: rd_mux[15:0] = rdis_word(rdis_reg, 3'h0);
            iprs_pkg::IDX_RDIS_1: rd_mux[15:0] = rdis_word(rdis_reg, 3'h1);
            iprs_pkg::IDX_RDIS_2: rd_mux[15:0] = rdis_word(rdis_reg, 3'h2);
            iprs_pkg::IDX_RDIS_3: rd_mux[15:0] = rdis_word(rdis_reg, 3'h3);
            iprs_pkg::IDX_RDIS_4: rd_mux[15:0] = rdis_word(rdis_reg, 3'h4);
            iprs_pkg::IDX_RDIS_5: rd_mux[15:0] = rdis_word(rdis_reg, 3'h5);
            iprs_pkg::IDX_RUN_CTRL: rd_mux[3:0] = {confirm, pwr_drop_i,
                                                  halt_reg, run_o};
            iprs_pkg::IDX_IRQ_STAT: rd_mux[2:0] = irq_stat_reg;
            iprs_pkg::IDX_IRQ_MASK: rd_mux[2:0] = irq_mask_reg;
            iprs_pkg::IDX_ACTIVE: rd_mux[15:0] = {en_act_reg, 3'h0,
                                                 tb_act_reg, dly_act_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered so they stand with waitrequest low
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_mux;
        end
    end

    // software-visible settings; free to change at any time
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tb_reg <= iprs_pkg::RST_SETTING;
            pwr_reg <= iprs_pkg::RST_SETTING;
            rdis_reg <= '0;
        end else if (wr_acc) begin
            case (idx)
                iprs_pkg::IDX_TIME_BASE: tb_reg <= avs_writedata_i[15:0];
                iprs_pkg::IDX_PWR_CTRL: pwr_reg <= avs_writedata_i[15:0];
                iprs_pkg::IDX_RDIS_0: rdis_reg[15:0] <= avs_writedata_i[15:0];
                iprs_pkg::IDX_RDIS_1: rdis_reg[31:16] <= avs_writedata_i[15:0];
                iprs_pkg::IDX_RDIS_2: rdis_reg[47:32] <= avs_writedata_i[15:0];
                iprs_pkg::IDX_RDIS_3: rdis_reg[63:48] <= avs_writedata_i[15:0];
                iprs_pkg::IDX_RDIS_4: rdis_reg[79:64] <= avs_writedata_i[15:0];
                iprs_pkg::IDX_RDIS_5: rdis_reg[95:80] <= avs_writedata_i[15:0];
                default: ;
            endcase
        end
    end

    // startup marker: the cycle right after reset release counts as startup
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            startup_reg <= 1'b1;
        end else begin
            startup_reg <= 1'b0;
        end
    end

    // time base taken only at start of operation
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tb_act_reg <= iprs_pkg::TB_10MS;
        end else if (run_start) begin
            tb_act_reg <= tb_reg[iprs_pkg::TB_W-1:0];
        end
    end

    // power-off delay, enable and refresh disables taken at startup or start
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dly_act_reg <= 8'h00;
            en_act_reg <= 1'b0;
            rdis_act_reg <= '0;
        end else if (capture) begin
            dly_act_reg <= pwr_reg[iprs_pkg::PWR_DLY_W-1:0];
            en_act_reg <= pwr_reg[iprs_pkg::PWR_EN_BIT];
            rdis_act_reg <= rdis_reg;
        end
    end

    // run and halt; a halt holds the processor reset until software clears it
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_o <= 1'b0;
            halt_reg <= 1'b0;
            cpu_reset_o <= 1'b0;
        end else if (confirm_rise && !en_act_reg) begin
            run_o <= 1'b0;
            halt_reg <= 1'b1;
            cpu_reset_o <= 1'b1;
        end else if (wr_acc && (idx == iprs_pkg::IDX_RUN_CTRL)) begin
            if (halt_reg) begin
                halt_reg <= !avs_writedata_i[iprs_pkg::HALT_CLR_BIT];
                cpu_reset_o <= !avs_writedata_i[iprs_pkg::HALT_CLR_BIT];
            end else begin
                run_o <= avs_writedata_i[iprs_pkg::RUN_BIT];
            end
        end
    end

    // 0.1 ms prescaler; long count kept as a parameter for simulation
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sub_cnt_reg <= 16'h0000;
            sub_tick_reg <= 1'b0;
        end else if (sub_cnt_reg == 16'(TICK_CYCLES - 1)) begin
            sub_cnt_reg <= 16'h0000;
            sub_tick_reg <= 1'b1;
        end else begin
            sub_cnt_reg <= sub_cnt_reg + 16'h0001;
            sub_tick_reg <= 1'b0;
        end
    end

    // millisecond tick; free running, so the first delay step may be short
    assign ms_tick = sub_tick_reg &&
                     (ms_cnt_reg == iprs_pkg::SUB_PER_MS - 4'h1);
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ms_cnt_reg <= 4'h0;
        end else if (ms_tick) begin
            ms_cnt_reg <= 4'h0;
        end else if (sub_tick_reg) begin
            ms_cnt_reg <= ms_cnt_reg + 4'h1;
        end
    end

    // scheduled tick length from the captured code; unused codes act as 10 ms
    always_comb begin
        case (tb_act_reg)
            iprs_pkg::TB_1MS: sched_len = iprs_pkg::SUB_PER_1MS;
            iprs_pkg::TB_100US: sched_len = iprs_pkg::SUB_PER_100US;
            default: sched_len = iprs_pkg::SUB_PER_10MS;
        endcase
    end

    // scheduled interrupt base tick, only while running
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sched_cnt_reg <= 7'h00;
            sched_tick_o <= 1'b0;
        end else if (!run_o) begin
            sched_cnt_reg <= 7'h00;
            sched_tick_o <= 1'b0;
        end else if (sub_tick_reg) begin
            if (sched_cnt_reg >= sched_len - 7'h01) begin
                sched_cnt_reg <= 7'h00;
                sched_tick_o <= 1'b1;
            end else begin
                sched_cnt_reg <= sched_cnt_reg + 7'h01;
                sched_tick_o <= 1'b0;
            end
        end else begin
            sched_tick_o <= 1'b0;
        end
    end

    // captured time base mirrored out for the scheduler
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            time_base_o <= iprs_pkg::TB_10MS;
        end else begin
            time_base_o <= tb_act_reg;
        end
    end

    // confirmation delay counter
    iprs_pwr_delay u_delay (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .detect_i(pwr_drop_i),
        .ms_tick_i(ms_tick),
        .delay_i(dly_act_reg),
        .confirm_o(confirm)
    );

    assign confirm_rise = confirm && !confirm_d_reg;

    // power-off task launch is a one-cycle request
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            confirm_d_reg <= 1'b0;
            pwr_task_o <= 1'b0;
        end else begin
            confirm_d_reg <= confirm;
            pwr_task_o <= confirm_rise && en_act_reg;
        end
    end

    // refresh gate: explicit instructions bypass the cyclic disable
    assign req_ok = refresh_req_i && (refresh_unit_i < iprs_pkg::UNIT_LIMIT);
    assign go = req_ok && (io_refresh_instruction_i ||
                !rdis_act_reg[refresh_unit_i]);
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            refresh_go_o <= 1'b0;
            refresh_skip_o <= 1'b0;
            refresh_base_o <= 10'h000;
        end else begin
            refresh_go_o <= go;
            refresh_skip_o <= req_ok && !go;
            if (req_ok) begin
                refresh_base_o <= unit_base(refresh_unit_i);
            end
        end
    end

    // sticky events; a new event wins over a same-cycle write-one clear
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_acc && (idx == iprs_pkg::IDX_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~avs_writedata_i[2:0];
        end
        irq_stat_next[iprs_pkg::IRQ_CONFIRM] =
            irq_stat_next[iprs_pkg::IRQ_CONFIRM] | confirm_rise;
        // the module raises this after its 11 s supervision lapses
        irq_stat_next[iprs_pkg::IRQ_HOST_FAULT] =
            irq_stat_next[iprs_pkg::IRQ_HOST_FAULT] | host_fault_indicator_i;
        irq_stat_next[iprs_pkg::IRQ_SKIP] =
            irq_stat_next[iprs_pkg::IRQ_SKIP] | (req_ok && !go);
    end

    // status, mask and the level interrupt
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_o <= |(irq_stat_next & irq_mask_reg);
            if (wr_acc && (idx == iprs_pkg::IDX_IRQ_MASK)) begin
                irq_mask_reg <= avs_writedata_i[2:0];
            end
        end
    end

    a_tb_held_run: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (run_o && $past(run_o)) |-> $stable(tb_act_reg))
        else $error("time base changed while running");

    a_pwr_held_run: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        (run_o && $past(run_o)) |->
        ($stable(dly_act_reg) && $stable(en_act_reg)))
        else $error("power-off settings changed while running");

    a_enable_capture: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        $past(startup_reg) |-> en_act_reg == $past(pwr_reg[15]))
        else $error("enable bit not captured at startup");

    a_task_launch: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        ($rose(confirm) && en_act_reg) |=> (pwr_task_o && !cpu_reset_o))
        else $error("power-off task not launched");

    a_halt_reset: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        ($rose(confirm) && !en_act_reg) |=>
        (cpu_reset_o && !run_o && !pwr_task_o))
        else $error("no reset and halt on confirmed drop");

    a_zero_delay: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        ($rose(pwr_drop_i) && dly_act_reg == 8'h00 && $stable(dly_act_reg))
        |=> confirm)
        else $error("zero delay did not confirm next cycle");

    a_refresh_skip: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        (req_ok && !io_refresh_instruction_i && rdis_act_reg[refresh_unit_i])
        |=> (!refresh_go_o && refresh_skip_o))
        else $error("disabled unit refreshed cyclically");

    a_explicit_go: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        (req_ok && io_refresh_instruction_i)
        |=> (refresh_go_o &&
             refresh_base_o == 10'($past(refresh_unit_i) * 10)))
        else $error("explicit refresh not granted");

    a_tb_tick_gap: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i)
        (sched_tick_o && tb_act_reg == 4'h2 && run_o) |-> ##1 !sched_tick_o)
        else $error("scheduled tick longer than one cycle");
endmodule : iprs_top
`default_nettype wire

//--- iprs_io_model.sv
// iprs_io_model: intelligent i/o modules watching for controller refresh
`timescale 1ns/100ps
`default_nettype none
module iprs_io_model #(
    parameter int LAPSE = 5000
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic refresh_go_i,
    output logic host_fault_indicator_o
);
    int idle_cnt;
    // lapse stands in for 11 s so the run stays short; the error latches
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idle_cnt <= 0;
            host_fault_indicator_o <= 1'b0;
        end else if (refresh_go_i) begin
            idle_cnt <= 0;
        end else if (idle_cnt < LAPSE) begin
            idle_cnt <= idle_cnt + 1;
        end else begin
            host_fault_indicator_o <= 1'b1;
        end
    end
endmodule : iprs_io_model
`default_nettype wire

//--- iprs_top_bench.sv
// iprs_top_bench: self-checking bench for the setup register bank
`timescale 1ns/100ps
`default_nettype none
module iprs_top_bench;
    localparam int TICK = 4;
    localparam int MS = 10 * TICK;
    logic clk, rstn, rd, wr, drop, rreq, rinstr, hfault;
    logic [9:0] addr, base;
    logic [31:0] wdata, rdata;
    logic [6:0] runit;
    logic wreq, ptask, creset, run, stick, go, skip, irq;
    logic [3:0] tb;
    int n_fail = 0;
    int samples_checked = 0;
    iprs_top #(.TICK_CYCLES(TICK)) DUT (.core_clk_i(clk), .rstn_i(rstn),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .pwr_drop_i(drop), .pwr_task_o(ptask),
        .cpu_reset_o(creset), .run_o(run), .sched_tick_o(stick),
        .time_base_o(tb), .refresh_req_i(rreq), .refresh_unit_i(runit),
        .io_refresh_instruction_i(rinstr), .refresh_go_o(go),
        .refresh_skip_o(skip), .refresh_base_o(base),
        .host_fault_indicator_i(hfault), .irq_o(irq));
    iprs_io_model #(.LAPSE(5000)) io_units (.core_clk_i(clk),
        .rstn_i(rstn), .refresh_go_i(go), .host_fault_indicator_o(hfault));
    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one bus cycle; held until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] idx, input logic [15:0] d,
             output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 100) chk(32'(wreq), 32'h0);
    endtask : bus
    task wrr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wrr
    task rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 16'h0000, q);
        chk(q, exp);
    endtask : rdc
    // edges until the chosen output is seen high, bounded by lim
    task wait_hi(input int which, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!((which == 0 && stick === 1'b1) ||
                     (which == 1 && ptask === 1'b1) ||
                     (which == 2 && creset === 1'b1)) && n < lim);
    endtask : wait_hi
    task t_reset;
        rdc(iprs_pkg::IDX_TIME_BASE, 32'h0);
        rdc(iprs_pkg::IDX_PWR_CTRL, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rdc(iprs_pkg::IDX_RDIS_0 + 8'(i), 32'h0);
        end
        wrr(iprs_pkg::IDX_RDIS_5, 16'hFFFF);
        rdc(iprs_pkg::IDX_RDIS_5, 32'h0000FFFF);
        wrr(iprs_pkg::IDX_RDIS_5, 16'h0000);
        wrr(8'h10, 16'h1234);
        rdc(8'h10, 32'h0);
    endtask : t_reset
    task t_time_base;
        int n;
        // default code first: 100 sub-ticks between base ticks
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        wait_hi(0, 2000, n);
        wait_hi(0, 2000, n);
        chk(32'(n), 32'(10 * MS));
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0000);
        wrr(iprs_pkg::IDX_TIME_BASE, 16'h0001);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        wait_hi(0, 2000, n);
        wait_hi(0, 2000, n);
        chk(32'(n), 32'(MS));
        wrr(iprs_pkg::IDX_TIME_BASE, 16'h0002);
        repeat (3) @(posedge clk);
        chk(32'(tb), 32'h1);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0000);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        wait_hi(0, 2000, n);
        wait_hi(0, 2000, n);
        chk(32'(n), 32'(TICK));
        chk(32'(tb), 32'h2);
    endtask : t_time_base
    task t_power_task;
        int n;
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0000);
        wrr(iprs_pkg::IDX_PWR_CTRL, 16'h8003);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        wrr(iprs_pkg::IDX_PWR_CTRL, 16'h0000);
        rdc(iprs_pkg::IDX_ACTIVE, 32'h00008203);
        @(posedge clk) drop <= 1'b1;
        wait_hi(1, 400, n);
        chk(32'(n >= 2 * MS - 1 && n <= 3 * MS + 4), 32'h1);
        chk(32'(creset), 32'h0);
        @(posedge clk) drop <= 1'b0;
        rdc(iprs_pkg::IDX_IRQ_STAT, 32'h1);
        // a set mask bit lets its status bit through to the interrupt
        wrr(iprs_pkg::IDX_IRQ_MASK, 16'h0000);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        wrr(iprs_pkg::IDX_IRQ_MASK, 16'h0007);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1);
        wrr(iprs_pkg::IDX_IRQ_STAT, 16'h0007);
        rdc(iprs_pkg::IDX_IRQ_STAT, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask : t_power_task
    task t_power_halt;
        int n;
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0000);
        wrr(iprs_pkg::IDX_PWR_CTRL, 16'h0000);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        @(posedge clk) drop <= 1'b1;
        wait_hi(2, 20, n);
        chk(32'(n), 32'h3);
        repeat (2) @(posedge clk);
        chk(32'({creset, run, ptask}), 32'h4);
        @(posedge clk) drop <= 1'b0;
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        @(posedge clk);
        chk(32'(run), 32'h0);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0002);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        repeat (2) @(posedge clk);
        chk(32'(run), 32'h1);
        chk(32'(creset), 32'h0);
        wrr(iprs_pkg::IDX_IRQ_STAT, 16'h0007);
    endtask : t_power_halt
    // one request; expect {go, skip, base} two edges on
    task req(input logic [6:0] u, input logic ins, input logic [11:0] exp);
        @(posedge clk);
        rreq <= 1'b1;
        runit <= u;
        rinstr <= ins;
        @(posedge clk);
        rreq <= 1'b0;
        rinstr <= 1'b0;
        @(posedge clk);
        chk(32'({go, skip, base}), 32'(exp));
    endtask : req
    task t_refresh;
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0000);
        wrr(iprs_pkg::IDX_RDIS_0, 16'h0020);
        wrr(iprs_pkg::IDX_RDIS_1, 16'h0001);
        wrr(iprs_pkg::IDX_RUN_CTRL, 16'h0001);
        req(7'd5, 1'b0, {2'b01, 10'd50});
        req(7'd5, 1'b1, {2'b10, 10'd50});
        req(7'd4, 1'b0, {2'b10, 10'd40});
        req(7'd16, 1'b0, {2'b01, 10'd160});
        req(7'h60, 1'b0, {2'b00, 10'd160});
        rdc(iprs_pkg::IDX_IRQ_STAT, 32'h4);
        wrr(iprs_pkg::IDX_IRQ_STAT, 16'h0007);
    endtask : t_refresh
    task t_host_fault;
        repeat (5100) @(posedge clk);
        rdc(iprs_pkg::IDX_IRQ_STAT, 32'h2);
        chk(32'(irq), 32'h1);
    endtask : t_host_fault
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // main sequence after a 16-cycle reset
    initial begin
        rstn = 1'b0;
        {rd, wr, drop, rreq, rinstr} = 5'h00;
        addr = 10'h000;
        wdata = 32'h0;
        runit = 7'h00;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_time_base;
        t_power_task;
        t_power_halt;
        t_refresh;
        t_host_fault;
        wrap_up;
    end
    // watchdog well beyond the expected span of the tests
    initial begin
        #(8 * 40000);
        n_fail++;
        wrap_up;
    end
endmodule : iprs_top_bench
`default_nettype wire
